// *** core/sdp_map.vh ***
// register offsets, field positions, memory map and timing counts
// assumes inclusion by every design file of the scanner data port block
`ifndef SDP_MAP_VH
`define SDP_MAP_VH
`define SDP_REG_PIXEL 7'h00
`define SDP_REG_LEVEL 7'h01
`define SDP_REG_SENSE 7'h02
`define SDP_REG_SELECT 7'h03
`define SDP_REG_ADDR_HI 7'h04
`define SDP_REG_ADDR_LO 7'h05
`define SDP_REG_PORT 7'h06
`define SDP_REG_COMMAND 7'h07
`define SDP_REG_TOP 7'h7F
`define SDP_SEL_RO_BIT 4
`define SDP_DIR_BIT 6
`define SDP_GAMMA_TOP 14'h0FFD
`define SDP_COEF_TOP 14'h3FFF
`define SDP_OFFSET_BASE 20'h00000
`define SDP_GAIN_BASE 20'h0C000
`define SDP_GAMMA_BASE 20'h18000
`define SDP_IMAGE_BASE 20'h1B000
`define SDP_SMALL_TOP 20'h3FFFF
`define SDP_LARGE_TOP 20'hFFFFF
`define SDP_COLOR_STEP 20'h04000
`define SDP_GAMMA_STEP 20'h01000
`define SDP_SLOT_NS 125
`define SDP_CLK_NS 50
`define SDP_SLOT_CYC ((`SDP_SLOT_NS + `SDP_CLK_NS - 1) / `SDP_CLK_NS)
`define SDP_TYPE_GAMMA 2'h0
`define SDP_TYPE_GAIN 2'h1
`define SDP_TYPE_OFFSET 2'h2
`endif

// *** core/sdp_dram_seq.v ***
// per-pixel dram access sequencer: one random cycle per slot
// assumes a plain async-style dram answering within one slot
`default_nettype none
module sdp_dram_seq (
    input wire CLK,
    input wire RST_N,
    input wire start,
    input wire [2:0] first_op,
    input wire single,
    output reg busy,
    output reg [2:0] op,
    output wire slot_end
);
`include "sdp_map.vh"
    localparam integer SLOT_INT = `SDP_SLOT_CYC;
    localparam [2:0] SLOT_CYC = SLOT_INT[2:0];
    reg [2:0] cnt_ff;
    // last cycle of the current slot
    assign slot_end = busy && cnt_ff == 3'h0;
    always @(posedge CLK)
    begin
        if (!RST_N)
        begin
            busy <= 1'b0;
            op <= 3'h0;
            cnt_ff <= 3'h0;
        end
        else if (!busy && start)
        begin
            busy <= 1'b1;
            op <= first_op;
            cnt_ff <= SLOT_CYC - 3'h1;
        end
        else if (busy && cnt_ff != 3'h0)
            cnt_ff <= cnt_ff - 3'h1;
        else if (busy && (single || op == 3'h5))
            busy <= 1'b0;
        else if (busy)
        begin
            op <= op + 3'h1;
            cnt_ff <= SLOT_CYC - 3'h1;
        end
    end
endmodule
`default_nettype wire

// *** core/sdp_top.v ***
// register access unit with indexed table port and dram budget
// assumes host byte accesses arrive as one-cycle strobes
`default_nettype none
module sdp_top (
    input wire CLK,
    input wire RST_N,
    input wire ADDR_WR,
    input wire DATA_WR,
    input wire DATA_RD,
    input wire [7:0] WDATA,
    output reg [7:0] RDATA,
    input wire LARGE_DRAM,
    input wire WIDE_MODE,
    input wire PIXEL_STB,
    input wire [15:0] PIXEL_IN,
    input wire [7:0] LEVEL_IN,
    input wire [7:0] SENSE_IN,
    input wire [7:0] PIXEL_OUT_IN,
    output wire [19:0] DRAM_ADDR,
    output reg [15:0] DRAM_WDATA,
    input wire [15:0] DRAM_RDATA,
    output wire DRAM_WE,
    output wire DRAM_CYCLE,
    output wire [2:0] DRAM_OP
);
`include "sdp_map.vh"
    reg [6:0] raddr_ff;
    reg [7:0] sel_ff;
    reg dir_ff;
    reg [13:0] paddr_ff;
    reg [7:0] cmd_ff;
    reg [7:0] regs_ff [8:127];
    reg phase_ff;
    reg [7:0] low_ff;
    reg [15:0] pre_ff;
    reg pre_ok_ff;
    reg half_ff;
    reg [7:0] held_ff;
    reg [19:0] img_ptr_ff;
    reg pix_pend_ff;
    reg [15:0] pix_word_ff;
    reg port_pend_ff;
    reg port_we_ff;
    reg [15:0] port_word_ff;
    reg [13:0] coef_idx_ff;
    wire [1:0] tbl = sel_ff[1:0];
    wire [1:0] col = sel_ff[3:2];
    wire [13:0] top = (tbl == `SDP_TYPE_GAMMA) ? `SDP_GAMMA_TOP : `SDP_COEF_TOP;
    wire [13:0] nxt_paddr = (paddr_ff == top) ? 14'h0000 : paddr_ff + 14'h0001;
    wire [13:0] nxt_coef = (coef_idx_ff == `SDP_COEF_TOP) ? 14'h0000 : coef_idx_ff + 14'h0001;
    wire [19:0] mem_top = LARGE_DRAM ? `SDP_LARGE_TOP : `SDP_SMALL_TOP;
    wire seq_busy;
    wire seq_end;
    wire [2:0] seq_op;
    wire port_start = port_pend_ff && !seq_busy;
    wire pix_start = pix_pend_ff && !seq_busy && !port_pend_ff;
    function [19:0] tbl_base;
        input [1:0] t;
        input [1:0] c;
        input [13:0] a;
        begin
            if (t == `SDP_TYPE_GAMMA)
                tbl_base = `SDP_GAMMA_BASE + `SDP_GAMMA_STEP * c + {6'h00, a};
            else if (t == `SDP_TYPE_GAIN)
                tbl_base = `SDP_GAIN_BASE + `SDP_COLOR_STEP * c + {6'h00, a};
            else
                tbl_base = `SDP_OFFSET_BASE + `SDP_COLOR_STEP * c + {6'h00, a};
        end
    endfunction
    reg [19:0] op_addr;
    always @*
    begin
        case (seq_op)
            3'h0: op_addr = tbl_base(`SDP_TYPE_OFFSET, col, coef_idx_ff);
            3'h1: op_addr = tbl_base(`SDP_TYPE_GAIN, col, coef_idx_ff);
            3'h2: op_addr = tbl_base(`SDP_TYPE_GAMMA, col, paddr_ff);
            3'h3: op_addr = img_ptr_ff;
            3'h4: op_addr = img_ptr_ff;
            default: op_addr = 20'h00000;
        endcase
    end
    assign DRAM_ADDR = (seq_op == 3'h6) ? tbl_base(tbl, col, paddr_ff) : op_addr;
    // refresh is a dram cycle too
    assign DRAM_CYCLE = seq_busy;
    assign DRAM_WE = seq_busy && (seq_op == 3'h3 || (seq_op == 3'h6 && port_we_ff));
    assign DRAM_OP = seq_op;
    sdp_dram_seq u_seq (
        .CLK(CLK),
        .RST_N(RST_N),
        .start(port_start | pix_start),
        .first_op(port_start ? 3'h6 : 3'h0),
        .single(port_start | (seq_op == 3'h6)),
        .busy(seq_busy),
        .op(seq_op),
        .slot_end(seq_end)
    );
    integer i;
    always @(posedge CLK)
    begin
        if (!RST_N)
        begin
            raddr_ff <= 7'h00;
            sel_ff <= 8'h00;
            dir_ff <= 1'b0;
            paddr_ff <= 14'h0000;
            cmd_ff <= 8'h00;
            phase_ff <= 1'b0;
            low_ff <= 8'h00;
            pre_ff <= 16'h0000;
            pre_ok_ff <= 1'b0;
            half_ff <= 1'b0;
            held_ff <= 8'h00;
            img_ptr_ff <= `SDP_IMAGE_BASE;
            coef_idx_ff <= 14'h0000;
            pix_pend_ff <= 1'b0;
            pix_word_ff <= 16'h0000;
            port_pend_ff <= 1'b0;
            port_we_ff <= 1'b0;
            port_word_ff <= 16'h0000;
            DRAM_WDATA <= 16'h0000;
            RDATA <= 8'h00;
            for (i = 8; i < 128; i = i + 1)
                regs_ff[i] <= 8'h00;
        end
        else
        begin
            if (ADDR_WR && WDATA[7] == 1'b0)
                raddr_ff <= WDATA[6:0];
            if (seq_end && seq_op == 3'h6)
            begin
                port_pend_ff <= 1'b0;
                if (port_we_ff)
                    paddr_ff <= nxt_paddr;
                else
                begin
                    pre_ff <= DRAM_RDATA;
                    pre_ok_ff <= 1'b1;
                    if (pre_ok_ff || phase_ff == 1'b0)
                        paddr_ff <= nxt_paddr;
                end
            end
            if (DATA_WR && raddr_ff == `SDP_REG_SELECT)
            begin
                sel_ff <= {WDATA[7:5], sel_ff[`SDP_SEL_RO_BIT], WDATA[3:0]};
            end
            if (DATA_WR && raddr_ff == `SDP_REG_ADDR_HI)
            begin
                paddr_ff[13:8] <= WDATA[5:0];
                dir_ff <= WDATA[`SDP_DIR_BIT];
                phase_ff <= 1'b0;
                pre_ok_ff <= 1'b0;
            end
            if (DATA_WR && raddr_ff == `SDP_REG_ADDR_LO)
            begin
                paddr_ff[7:0] <= WDATA;
                phase_ff <= 1'b0;
                pre_ok_ff <= 1'b0;
                if (dir_ff)
                begin
                    port_pend_ff <= 1'b1;
                    port_we_ff <= 1'b0;
                end
            end
            if (DATA_WR && raddr_ff == `SDP_REG_COMMAND)
                cmd_ff <= WDATA;
            if (DATA_WR && raddr_ff > `SDP_REG_COMMAND)
                regs_ff[raddr_ff] <= WDATA;
            if (DATA_WR && raddr_ff == `SDP_REG_PORT && !dir_ff)
            begin
                if (!phase_ff)
                    low_ff <= WDATA;
                else
                begin
                    port_word_ff <= {low_ff, WDATA};
                    port_pend_ff <= 1'b1;
                    port_we_ff <= 1'b1;
                end
                phase_ff <= ~phase_ff;
            end
            if (DATA_RD && raddr_ff == `SDP_REG_PORT && dir_ff)
            begin
                if (phase_ff)
                begin
                    pre_ok_ff <= 1'b0;
                    port_pend_ff <= 1'b1;
                    port_we_ff <= 1'b0;
                end
                phase_ff <= ~phase_ff;
            end
            if (port_start)
                DRAM_WDATA <= port_word_ff;
            if (pix_start)
            begin
                pix_pend_ff <= 1'b0;
                DRAM_WDATA <= pix_word_ff;
            end
            if (PIXEL_STB)
            begin
                if (WIDE_MODE)
                begin
                    pix_word_ff <= PIXEL_IN;
                    pix_pend_ff <= 1'b1;
                end
                else if (!half_ff)
                begin
                    held_ff <= PIXEL_IN[7:0];
                    half_ff <= 1'b1;
                end
                else
                begin
                    pix_word_ff <= {held_ff, PIXEL_IN[7:0]};
                    pix_pend_ff <= 1'b1;
                    half_ff <= 1'b0;
                end
            end
            if (seq_end && seq_op == 3'h3)
                img_ptr_ff <= (img_ptr_ff == mem_top) ? `SDP_IMAGE_BASE : img_ptr_ff + 20'h00001;
            if (seq_end && seq_op == 3'h5)
                coef_idx_ff <= nxt_coef;
            if (DATA_RD)
            begin
                case (raddr_ff)
                    `SDP_REG_PIXEL: RDATA <= PIXEL_OUT_IN;
                    `SDP_REG_LEVEL: RDATA <= LEVEL_IN;
                    `SDP_REG_SENSE: RDATA <= SENSE_IN;
                    `SDP_REG_SELECT: RDATA <= sel_ff;
                    `SDP_REG_ADDR_HI: RDATA <= {1'b0, dir_ff, paddr_ff[13:8]};
                    `SDP_REG_ADDR_LO: RDATA <= paddr_ff[7:0];
                    `SDP_REG_PORT: RDATA <= phase_ff ? pre_ff[7:0] : pre_ff[15:8];
                    `SDP_REG_COMMAND: RDATA <= cmd_ff;
                    default: RDATA <= regs_ff[raddr_ff];
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// *** test/sdp_props.sv ***
// assertions on the scanner data port block ports
// assumes a bind onto sdp_top
`default_nettype none
module sdp_props (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic ADDR_WR,
    input wire logic DATA_WR,
    input wire logic DATA_RD,
    input wire logic [7:0] WDATA,
    input wire logic [7:0] RDATA,
    input wire logic LARGE_DRAM,
    input wire logic [7:0] LEVEL_IN,
    input wire logic [7:0] SENSE_IN,
    input wire logic [7:0] PIXEL_OUT_IN,
    input wire logic [19:0] DRAM_ADDR,
    input wire logic DRAM_WE,
    input wire logic DRAM_CYCLE,
    input wire logic [2:0] DRAM_OP
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [6:0] held_ff;
    logic dir_ff;
    logic ph_ff;
    wire port = held_ff == 7'h06;
    always @(posedge CLK)
        held_ff <= !RST_N ? 7'h00 : (ADDR_WR && !WDATA[7]) ? WDATA[6:0] : held_ff;
    always @(posedge CLK)
        dir_ff <= !RST_N ? 1'b0 : (DATA_WR && held_ff == 7'h04) ? WDATA[6] : dir_ff;
    always @(posedge CLK)
        ph_ff <= (!RST_N || (DATA_WR && held_ff[6:1] == 6'h02)) ? 1'b0 :
            (port && ((DATA_WR && !dir_ff) || (DATA_RD && dir_ff))) ? !ph_ff : ph_ff;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    a_level_read: assert property (DATA_RD && held_ff == 7'h01 |=> RDATA == $past(LEVEL_IN))
        else $error("level read mismatch");
    a_sense_read: assert property (DATA_RD && held_ff == 7'h02 |=> RDATA == $past(SENSE_IN))
        else $error("sense read mismatch");
    a_pixel_read: assert property (DATA_RD && held_ff == 7'h00 |=> RDATA == $past(PIXEL_OUT_IN))
        else $error("pixel read mismatch");
    a_rdata_holds: assert property (!DATA_RD |=> $stable(RDATA))
        else $error("read data moved");
    a_we_in_cycle: assert property (DRAM_WE |-> DRAM_CYCLE)
        else $error("write outside cycle");
    a_small_range: assert property (DRAM_CYCLE && !LARGE_DRAM |-> DRAM_ADDR <= 20'h3FFFF)
        else $error("address beyond small memory");
    a_port_word: assert property (DATA_WR && port && ph_ff && !dir_ff |=>
        ##1 (DRAM_CYCLE && DRAM_WE && DRAM_OP == 3'h6)[*3])
        else $error("port word not written");
    a_half_quiet: assert property (DATA_WR && port && !ph_ff && !dir_ff |=> !(DRAM_CYCLE && DRAM_OP == 3'h6))
        else $error("access after first byte");
    a_read_dir: assert property (DATA_WR && port && dir_ff |=> !DRAM_WE[*3])
        else $error("write while reading");
    a_slot_order: assert property ($changed(DRAM_OP) && DRAM_OP == 3'h5 |-> $past(DRAM_OP) == 3'h4)
        else $error("refresh out of order");
    cover property (DATA_WR && port && ph_ff);
    cover property (DRAM_CYCLE && DRAM_OP == 3'h5);
    cover property (DATA_RD && held_ff == 7'h01);
endmodule
`default_nettype wire

// *** test/sdp_dram_model.sv ***
// word-wide dram model on the far side of the block
// assumes one access per asserted cycle
`default_nettype none
module sdp_dram_model (
    input wire logic clk,
    input wire logic cycle,
    input wire logic we,
    input wire logic [2:0] op,
    input wire logic [19:0] addr,
    input wire logic [15:0] wdata,
    output logic [15:0] rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem [bit [19:0]];
    logic [19:0] lw_addr = 20'h00000;
    logic [15:0] lw_data = 16'h0000;
    logic [7:0] ops_seen = 8'h00;
    logic prev_wr = 1'b0;
    int n_wr = 0;
    initial rdata = 16'h5A5A;
    always @(posedge clk)
    begin
        prev_wr <= cycle && we;
        if (cycle)
            ops_seen[op] <= 1'b1;
        if (cycle && we)
        begin
            mem[addr] = wdata;
            lw_addr <= addr;
            lw_data <= wdata;
        end
        if (cycle && we && !prev_wr)
            n_wr <= n_wr + 1;
        rdata <= (cycle && !we) ? (mem.exists(addr) ? mem[addr] : ~addr[15:0]) : ~rdata;
    end
endmodule
`default_nettype wire

// *** test/tb.sv ***
// host-side bench for the scanner data port block
// assumes sdp_top, sdp_dram_model and sdp_props
`include "sdp_map.vh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic CLK = 0, RST_N = 0, ADDR_WR = 0, DATA_WR = 0, DATA_RD = 0, LARGE_DRAM = 0;
    logic WIDE_MODE = 0, PIXEL_STB = 0, DRAM_WE, DRAM_CYCLE;
    logic [7:0] WDATA = 0, LEVEL_IN = 8'h3C, SENSE_IN = 8'hC3, PIXEL_OUT_IN = 8'h96, RDATA;
    logic [15:0] PIXEL_IN = 0, DRAM_WDATA, DRAM_RDATA;
    logic [19:0] DRAM_ADDR;
    logic [2:0] DRAM_OP;
    int n_mismatch = 0, samples_checked = 0, cyc = 0, w0;
    sdp_top u_dut (.CLK(CLK), .RST_N(RST_N), .ADDR_WR(ADDR_WR), .DATA_WR(DATA_WR),
        .DATA_RD(DATA_RD), .WDATA(WDATA), .RDATA(RDATA), .LARGE_DRAM(LARGE_DRAM),
        .WIDE_MODE(WIDE_MODE), .PIXEL_STB(PIXEL_STB), .PIXEL_IN(PIXEL_IN), .LEVEL_IN(LEVEL_IN),
        .SENSE_IN(SENSE_IN), .PIXEL_OUT_IN(PIXEL_OUT_IN), .DRAM_ADDR(DRAM_ADDR),
        .DRAM_WDATA(DRAM_WDATA), .DRAM_RDATA(DRAM_RDATA), .DRAM_WE(DRAM_WE),
        .DRAM_CYCLE(DRAM_CYCLE), .DRAM_OP(DRAM_OP));
    sdp_dram_model u_mem (.clk(CLK), .cycle(DRAM_CYCLE), .we(DRAM_WE), .op(DRAM_OP),
        .addr(DRAM_ADDR), .wdata(DRAM_WDATA), .rdata(DRAM_RDATA));
    initial forever #25 CLK = ~CLK;
    task automatic chk(input string what, input logic [19:0] exp, got);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic strobe(input int kind, input logic [7:0] d);
        @(negedge CLK);
        WDATA = d;
        {ADDR_WR, DATA_WR, DATA_RD} = {kind == 0, kind == 1, kind == 2};
        @(negedge CLK);
        {ADDR_WR, DATA_WR, DATA_RD} = 3'h0;
    endtask
    task automatic wreg(input logic [7:0] a, d);
        strobe(0, a);
        strobe(1, d);
    endtask
    task automatic rreg(input string what, input logic [7:0] exp);
        strobe(2, 8'h00);
        @(negedge CLK);
        chk(what, {12'h0, exp}, {12'h0, RDATA});
    endtask
    task automatic wword(input logic [15:0] w);
        strobe(1, w[15:8]);
        strobe(1, w[7:0]);
        repeat (4) @(negedge CLK);
    endtask
    task automatic rword(input string what, input logic [15:0] w);
        rreg(what, w[15:8]);
        rreg(what, w[7:0]);
        repeat (3) @(negedge CLK);
    endtask
    task automatic pixel(input logic [15:0] p);
        @(negedge CLK);
        {PIXEL_IN, PIXEL_STB} = {p, 1'b1};
        @(negedge CLK);
        PIXEL_STB = 0;
        repeat (24) @(negedge CLK);
    endtask
    task tally_and_finish;
        $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge CLK)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_mismatch++;
            tally_and_finish;
        end
    end
    initial
    begin
        repeat (5) @(negedge CLK);
        RST_N = 1;
        pixel(16'h0011);
        chk("first packed pixel", 20'h0, u_mem.n_wr[19:0]);
        pixel(16'h0022);
        chk("packed pixel", 20'h01122, {4'h0, u_mem.lw_data});
        chk("image region", 20'h1, {19'h0, u_mem.lw_addr >= `SDP_IMAGE_BASE});
        WIDE_MODE = 1;
        pixel(16'hBEEF);
        chk("wide pixel", 20'h0BEEF, {4'h0, u_mem.lw_data});
        chk("slot ops", 20'h0003F, {12'h0, u_mem.ops_seen});
        strobe(0, 8'h01);
        rreg("level", 8'h3C);
        LEVEL_IN = 8'h5A;
        rreg("level again", 8'h5A);
        strobe(0, 8'h02);
        rreg("sense", 8'hC3);
        strobe(0, 8'h00);
        rreg("pixel out", 8'h96);
        wreg(8'h03, 8'hFF);
        rreg("select", 8'hEF);
        wreg(8'h7F, 8'h5A);
        rreg("top reg", 8'h5A);
        wreg(8'h07, 8'h00);
        rreg("command idle", 8'h00);
        wreg(8'h03, 8'h05);
        wreg(8'h04, 8'h00);
        wreg(8'h05, 8'h02);
        strobe(0, 8'h06);
        wword(16'h1234);
        wword(16'hABCD);
        chk("gain word", 20'h01234, u_mem.mem[`SDP_GAIN_BASE + `SDP_COLOR_STEP + 20'h2]);
        chk("next word", 20'h0ABCD, u_mem.mem[`SDP_GAIN_BASE + `SDP_COLOR_STEP + 20'h3]);
        wreg(8'h03, 8'h08);
        wreg(8'h04, 8'h0F);
        wreg(8'h05, 8'hFD);
        strobe(0, 8'h06);
        wword(16'h0F0F);
        wword(16'h0A0A);
        w0 = `SDP_GAMMA_BASE + `SDP_GAMMA_STEP + `SDP_GAMMA_STEP;
        chk("gamma top", 20'h00F0F, u_mem.mem[w0[19:0] + 20'hFFD]);
        chk("gamma wrap", 20'h00A0A, u_mem.mem[w0[19:0]]);
        pixel(16'h0033);
        chk("pixel after port", 20'h00033, {4'h0, u_mem.lw_data});
        chk("pixel in image", 20'h1, {19'h0, u_mem.lw_addr >= `SDP_IMAGE_BASE});
        wreg(8'h03, 8'h05);
        wreg(8'h04, 8'h40);
        wreg(8'h05, 8'h02);
        strobe(0, 8'h06);
        repeat (2) @(negedge CLK);
        rword("port read", 16'h1234);
        rword("port read next", 16'hABCD);
        w0 = u_mem.n_wr;
        wword(16'hFFFF);
        chk("ignored write", w0[19:0], u_mem.n_wr[19:0]);
        tally_and_finish;
    end
endmodule
bind sdp_top sdp_props u_props (.CLK(CLK), .RST_N(RST_N), .ADDR_WR(ADDR_WR),
    .DATA_WR(DATA_WR), .DATA_RD(DATA_RD), .WDATA(WDATA), .RDATA(RDATA),
    .LARGE_DRAM(LARGE_DRAM), .LEVEL_IN(LEVEL_IN), .SENSE_IN(SENSE_IN),
    .PIXEL_OUT_IN(PIXEL_OUT_IN), .DRAM_ADDR(DRAM_ADDR), .DRAM_WE(DRAM_WE),
    .DRAM_CYCLE(DRAM_CYCLE), .DRAM_OP(DRAM_OP));
`default_nettype wire
